// >>> ptt_params.svh
/*
 * Register indices, field positions, reset values and prescale figures
 * of the periodic tick timer. Definitions only; included by bare name.
 */
`ifndef PTT_PARAMS_SVH
`define PTT_PARAMS_SVH

// Register indices; byte address is four times the index
`define PTT_IDX_CTRL     8'h0b
`define PTT_IDX_CLKCFG   8'h10
`define PTT_IDX_STATUS   8'h11
`define PTT_IDX_MASK     8'h12

// Reset values
`define PTT_CTRL_RST     8'h00
`define PTT_CLKCFG_RST   3'h0
`define PTT_STATUS_RST   1'h0
`define PTT_MASK_RST     1'h0

// Control register fields
`define PTT_DEC_BIT      7
`define PTT_RATE_HI      6
`define PTT_RATE_LO      4
`define PTT_MOD_HI       3
`define PTT_MOD_LO       0

// Clock configuration register fields
`define PTT_CLKSEL_BIT   0
`define PTT_PRE_BIT      1
`define PTT_PSEUDO_STOP_SELECT_BIT     2

// Status and mask field
`define PTT_TICK_BIT     0

// Binary family: code 1 gives 2^10 source clocks
`define PTT_BIN_EXP_BASE 5'd9

// Decimal family prescale rates, codes 0 to 7
`define PTT_DEC_R0       22'd1000
`define PTT_DEC_R1       22'd2000
`define PTT_DEC_R2       22'd5000
`define PTT_DEC_R3       22'd10000
`define PTT_DEC_R4       22'd20000
`define PTT_DEC_R5       22'd50000
`define PTT_DEC_R6       22'd100000
`define PTT_DEC_R7       22'd200000

// Least counter width serving 16 x 200000 clocks
`define PTT_CNT_W_MIN    22

`endif

// >>> ptt_pkg.sv
/*
 * Types shared by the periodic tick timer.
 * Assumes ptt_params.svh for the figures themselves.
 */
package ptt_pkg;

    // Prescaler family picked by the divider style bit
    typedef enum logic {
        PTT_BINARY,
        PTT_DECIMAL
    } ptt_family_t;

    // Divide value, wide enough for the largest decimal setting
    typedef logic [21:0] ptt_count_t;

endpackage

// >>> ptt_tick_timer.sv
/*
 * Periodic tick timer with classic Wishbone slave registers.
 * Assumes one clock clk_sys (200 MHz); the internal RC and oscillator
 * source clocks arrive as one-cycle enable pulses synchronous to clk_sys,
 * and stop mode and oscillator-up are synchronous levels.
 */
// Notes on behaviour
// - Counter advances on RC ticks when clock select is 0, oscillator ticks when 1.
// - In stop mode counting continues only with pseudo stop and oscillator source.
// - Control register reads and writes are always allowed, no gating.
// - Any control register write clears the counter and starts a new period.
// - Changing clock select or losing oscillator-up restarts the current period.
// - Bit 7 picks binary (0) or decimal (1) prescale rates.
// - Binary prescale code 0 is off; codes 1 to 7 give 2^10 to 2^16.
// - Modulus field multiplies the prescale rate by its value plus one.
// - After reset the control register is zero, timer disabled.
// - Decimal codes give 1000 to 200000 clocks, times modulus, never off.
// - Clock select takes 1 only while oscillator is up; forced 0 otherwise.
// - Pseudo stop runs only with enable bit and oscillator source; else hold.
`include "ptt_params.svh"

module ptt_tick_timer #(
    parameter int CNT_W = 22,
    parameter int ADR_W = 10
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic                   wb_ack_o,
    input  wire logic              internalRcTick,
    input  wire logic              oscillatorTick,
    input  wire logic              oscillatorUpFlag,
    input  wire logic              stopMode,
    output logic                   tickIrq
);

    // Refuse widths the divide value or the register index cannot fit
    if (CNT_W < `PTT_CNT_W_MIN || ADR_W < 10) begin : gParamCheck
        $error("ptt_tick_timer: CNT_W or ADR_W too small");
    end

    // Divide value for a control setting; zero means the timer is off
    function automatic ptt_pkg::ptt_count_t divideOf(input logic [7:0] ctrl);
        ptt_pkg::ptt_count_t rate;
        ptt_pkg::ptt_count_t mult;
        logic [2:0]          code;
        rate = '0;
        code = ctrl[`PTT_RATE_HI:`PTT_RATE_LO];
        mult = {18'h0, ctrl[`PTT_MOD_HI:`PTT_MOD_LO]} + 22'h1;
        if (ctrl[`PTT_DEC_BIT] == ptt_pkg::PTT_DECIMAL) begin
            case (code)
                3'h0:    rate = `PTT_DEC_R0;
                3'h1:    rate = `PTT_DEC_R1;
                3'h2:    rate = `PTT_DEC_R2;
                3'h3:    rate = `PTT_DEC_R3;
                3'h4:    rate = `PTT_DEC_R4;
                3'h5:    rate = `PTT_DEC_R5;
                3'h6:    rate = `PTT_DEC_R6;
                default: rate = `PTT_DEC_R7;
            endcase
            divideOf = 22'(rate * mult);
        end else if (code == 3'h0) begin
            divideOf = '0;
        end else begin
            divideOf = 22'(mult << (5'(code) + `PTT_BIN_EXP_BASE));
        end
    endfunction

    // Bus decode
    logic       wbReq;
    logic       wbWrite;
    logic [7:0] regIdx;
    logic       ackR;

    assign wbReq   = wb_cyc_i && wb_stb_i;
    assign regIdx  = wb_adr_i[9:2];
    // Writes land on the edge where the master samples ack
    assign wbWrite = wbReq && wb_we_i && ackR && wb_sel_i[0];
    assign wb_ack_o = ackR;

    // Registers
    logic [7:0] ctrlR;
    logic       clkSelR;
    logic       pseudoStopEnR;
    logic       pseudoStopSelR;
    logic       statusR;
    logic       maskR;
    logic       oscUpD;

    logic ctrlWr;
    logic clkCfgWr;
    logic statusWr;
    logic maskWr;

    assign ctrlWr   = wbWrite && regIdx == `PTT_IDX_CTRL;
    assign clkCfgWr = wbWrite && regIdx == `PTT_IDX_CLKCFG;
    assign statusWr = wbWrite && regIdx == `PTT_IDX_STATUS;
    assign maskWr   = wbWrite && regIdx == `PTT_IDX_MASK;

    // One-wait-state ack; dropped the cycle after it was given
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ackR <= 1'b0;
        end else begin
            ackR <= wbReq && !ackR;
        end
    end

    // Read data captured in the request cycle, shown with ack
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (wbReq && !ackR) begin
            case (regIdx)
                `PTT_IDX_CTRL:   wb_dat_o <= {24'h0, ctrlR};
                `PTT_IDX_CLKCFG: wb_dat_o <= {29'h0, pseudoStopSelR,
                                              pseudoStopEnR, clkSelR};
                `PTT_IDX_STATUS: wb_dat_o <= {31'h0, statusR};
                `PTT_IDX_MASK:   wb_dat_o <= {31'h0, maskR};
                default:         wb_dat_o <= 32'h0; // Unmapped reads zero
            endcase
        end
    end

    // Control register: open to software at any time
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrlR <= `PTT_CTRL_RST;
        end else if (ctrlWr) begin
            ctrlR <= wb_dat_i[7:0];
        end
    end

    // Clock configuration; the select bit is forced to 0 while the oscillator is down
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clkSelR        <= 1'b0;
            pseudoStopEnR  <= 1'b0;
            pseudoStopSelR <= 1'b0;
        end else begin
            if (!oscillatorUpFlag) begin
                clkSelR <= 1'b0;
            end else if (clkCfgWr) begin
                clkSelR <= wb_dat_i[`PTT_CLKSEL_BIT];
            end
            if (clkCfgWr) begin
                pseudoStopEnR  <= wb_dat_i[`PTT_PRE_BIT];
                pseudoStopSelR <= wb_dat_i[`PTT_PSEUDO_STOP_SELECT_BIT];
            end
        end
    end

    // Delayed oscillator status to see it fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oscUpD <= 1'b0;
        end else begin
            oscUpD <= oscillatorUpFlag;
        end
    end

    // Counting conditions
    logic                clkSelChange;
    logic                oscLost;
    logic                restart;
    logic                srcTick;
    logic                running;
    logic                tickEvent;
    ptt_pkg::ptt_count_t divTarget;
    logic [CNT_W-1:0]    cntR;

    assign clkSelChange = clkCfgWr && oscillatorUpFlag
                          && wb_dat_i[`PTT_CLKSEL_BIT] != clkSelR;
    assign oscLost   = oscUpD && !oscillatorUpFlag;
    assign restart   = ctrlWr || clkSelChange || oscLost;
    assign srcTick   = clkSelR ? oscillatorTick : internalRcTick;
    // Stop mode freezes the count unless pseudo stop keeps the oscillator
    assign running   = !stopMode
                       || (pseudoStopSelR && pseudoStopEnR && clkSelR);
    assign divTarget = divideOf(ctrlR);
    assign tickEvent = !restart && running && srcTick && divTarget != '0
                       && cntR == CNT_W'(divTarget - 22'h1);

    // Tick counter; the halt keeps the count, restarts clear it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cntR <= '0;
        end else if (restart || divTarget == '0) begin
            cntR <= '0;
        end else if (tickEvent) begin
            cntR <= '0;
        end else if (running && srcTick) begin
            cntR <= cntR + CNT_W'(1);
        end
    end

    // Sticky tick flag; a new tick beats a clearing write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            statusR <= `PTT_STATUS_RST;
        end else if (tickEvent) begin
            statusR <= 1'b1;
        end else if (statusWr && wb_dat_i[`PTT_TICK_BIT]) begin
            statusR <= 1'b0;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            maskR <= `PTT_MASK_RST;
        end else if (maskWr) begin
            maskR <= wb_dat_i[`PTT_TICK_BIT];
        end
    end

    // Level request while an unmasked flag is set
    assign tickIrq = statusR && maskR;

    AST_RC_SOURCE_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clkSelR && !internalRcTick && !restart |=> cntR == $past(cntR))
        else $error("counter moved without an RC tick");

    AST_STOP_HOLDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stopMode && !(pseudoStopSelR && pseudoStopEnR && clkSelR) && !restart
        && divTarget != '0 |=> cntR == $past(cntR))
        else $error("counter moved in stop mode");

    AST_CTRL_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wbReq && wb_we_i && wb_sel_i[0] && ackR && regIdx == `PTT_IDX_CTRL
        |=> ctrlR == $past(wb_dat_i[7:0]))
        else $error("control write not stored");

    AST_WRITE_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrlWr |=> cntR == '0)
        else $error("control write did not clear counter");

    AST_OSC_LOSS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(oscillatorUpFlag) |=> cntR == '0 && !clkSelR)
        else $error("oscillator loss did not restart period");

    AST_DEC_FAMILY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrlR[`PTT_DEC_BIT] && ctrlR[6:4] == 3'h0 && ctrlR[3:0] == 4'h1
        |-> divTarget == 22'd2000)
        else $error("decimal family wrong");

    AST_BIN_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrlR[`PTT_DEC_BIT] && ctrlR[6:4] == 3'h0 |=> cntR == '0 && !tickEvent)
        else $error("binary off code still counts");

    AST_BIN_MOD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrlR[`PTT_DEC_BIT] && ctrlR[6:4] == 3'h3 |->
        divTarget == 22'(({18'h0, ctrlR[3:0]} + 22'h1) << 12))
        else $error("binary divide value wrong");

    AST_RESET_OFF: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> ctrlR == 8'h00 && divTarget == '0)
        else $error("timer not off after reset");

    AST_DEC_MAX: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrlR == 8'hff |-> divTarget == 22'd3200000)
        else $error("decimal top divide value wrong");

    AST_SEL_NEEDS_OSC: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !oscillatorUpFlag |=> !clkSelR)
        else $error("clock select set without oscillator");

    AST_PSEUDO_RUNS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stopMode && pseudoStopSelR && pseudoStopEnR && clkSelR && oscillatorTick
        && !restart && !tickEvent && divTarget != '0 |=> cntR == $past(cntR) + 1)
        else $error("pseudo stop did not keep counting");

    AST_TICK_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tickEvent |=> statusR && cntR == '0 ##0 (maskR == tickIrq))
        else $error("tick did not set flag and restart");

    // Each request gets exactly one ack, one cycle after it is seen
    AST_ACK_ANSWERS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wbReq && !ackR |=> ackR)
        else $error("request not acknowledged");

    // Ack is a single-cycle pulse so the master cannot double-count a write
    AST_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ackR |=> !ackR)
        else $error("ack held longer than one cycle");

    // Control reads show the stored setting while ack stands
    AST_READ_CTRL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wbReq && !wb_we_i && ackR && regIdx == `PTT_IDX_CTRL
        |-> wb_dat_o[7:0] == ctrlR)
        else $error("control read data wrong");

    // An RC tick on the RC source moves the count by exactly one
    AST_RC_COUNTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clkSelR && internalRcTick && running && !restart && !tickEvent
        && divTarget != '0 |=> cntR == $past(cntR) + 1)
        else $error("RC tick did not advance counter");

    // On the oscillator source only oscillator ticks count
    AST_OSC_SOURCE_ONLY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkSelR && !oscillatorTick && !restart |=> cntR == $past(cntR))
        else $error("counter moved without an oscillator tick");

    // A new select value throws away the partial period
    AST_SELECT_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clkSelChange |=> cntR == '0)
        else $error("select change did not restart period");

    // The count always stays short of the divide value
    AST_CNT_BELOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        divTarget != '0 |-> cntR < CNT_W'(divTarget))
        else $error("counter passed the divide value");

    // Decimal family has no off code
    AST_DEC_NEVER_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrlR[`PTT_DEC_BIT] |-> divTarget != '0)
        else $error("decimal setting turned timer off");

    // Flag stays until software writes a one to it
    AST_STATUS_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        statusR && !(statusWr && wb_dat_i[`PTT_TICK_BIT]) |=> statusR)
        else $error("tick flag lost without a clear");

    // A tick in the same cycle as a clear must not be lost
    AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tickEvent && statusWr |=> statusR)
        else $error("clear beat a new tick");

    // Main scenarios worth seeing at least once
    COV_TICK: cover property (@(posedge clk_sys) disable iff (!rst_n)
        tickEvent && maskR);
    COV_PSEUDO: cover property (@(posedge clk_sys) disable iff (!rst_n)
        stopMode && running && srcTick);
    COV_SET_VS_CLEAR: cover property (@(posedge clk_sys) disable iff (!rst_n)
        tickEvent && statusWr && wb_dat_i[0]);
    COV_OSC_LOSS: cover property (@(posedge clk_sys) disable iff (!rst_n)
        oscLost && clkSelR);

    COV_DEC_TICK: cover property (@(posedge clk_sys) disable iff (!rst_n)
        tickEvent && ctrlR[`PTT_DEC_BIT]);

endmodule

// >>> tb_top.sv
/*
 * Self-checking bench for the periodic tick timer: registers, periods,
 * clock select, stop mode and the tick interrupt.
 * Assumes the source clocks are single-cycle enable pulses on clk_sys.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [9:0]  wbAdr = 10'h000;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic        wbWe = 1'b0;
    logic [3:0]  wbSel = 4'h0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbAck;
    logic        rcTick = 1'b0;
    logic        oscTick = 1'b0;
    logic        oscUp = 1'b0;
    logic        stopMode = 1'b0;
    logic        tickIrq;
    int          miscompares = 0;
    int          tests_run = 0;

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    ptt_tick_timer u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_ack_o(wbAck), .internalRcTick(rcTick),
        .oscillatorTick(oscTick), .oscillatorUpFlag(oscUp),
        .stopMode(stopMode), .tickIrq(tickIrq));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // One classic cycle; waits for ack however long it takes, the watchdog ends a hang
    task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_sys);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a;
        wbDatW <= {24'h0, d}; wbSel <= s;
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rdchk(input string what, input logic [9:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, 4'hf, q);
        chk(what, {24'h0, e}, q);
    endtask

    // n back-to-back source pulses; results land by the last edge
    task automatic ticks(input logic osc, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            rcTick <= ~osc;
            oscTick <= osc;
        end
        @(posedge clk_sys);
        rcTick <= 1'b0;
        oscTick <= 1'b0;
        #1;
    endtask

    // Exact period: silent one pulse short, raised on the last one
    task automatic period(input logic osc, input logic [7:0] ctrl, input int div);
        wr(10'h02c, ctrl);
        ticks(osc, div - 1);
        chk("irq early", 32'h0, {31'h0, tickIrq});
        ticks(osc, 1);
        chk("irq due", 32'h1, {31'h0, tickIrq});
        wr(10'h044, 8'h01);
        #1 chk("irq cleared", 32'h0, {31'h0, tickIrq});
    endtask

    task automatic t_regs;
        logic [31:0] q;
        rdchk("ctrl reset", 10'h02c, 8'h00);
        rdchk("clkcfg reset", 10'h040, 8'h00);
        rdchk("status reset", 10'h044, 8'h00);
        rdchk("mask reset", 10'h048, 8'h00);
        wr(10'h02c, 8'h81);
        wr(10'h02c, 8'h35);
        wr(10'h02c, 8'hff);
        rdchk("ctrl top", 10'h02c, 8'hff);
        wr(10'h02c, 8'ha5);
        rdchk("ctrl rw", 10'h02c, 8'ha5);
        wb(1'b1, 10'h02c, 8'h33, 4'he, q);
        rdchk("ctrl sel0 low", 10'h02c, 8'ha5);
        rdchk("unmapped", 10'h3fc, 8'h00);
        wr(10'h048, 8'h01);
    endtask

    task automatic t_rates;
        period(1'b0, 8'h10, 2 ** 10);
        period(1'b0, 8'h20, 2 ** 11);
        period(1'b0, 8'h1f, 16 * 2 ** 10);
        period(1'b0, 8'h80, 1000);
        period(1'b0, 8'h90, 2000);
        period(1'b0, 8'ha1, 2 * 5000);
    endtask

    task automatic t_off_mask;
        wr(10'h02c, 8'h0f);
        ticks(1'b0, 3000);
        chk("off code", 32'h0, {31'h0, tickIrq});
        wr(10'h048, 8'h00);
        wr(10'h02c, 8'h10);
        ticks(1'b0, 2 ** 10 - 1);
        rdchk("status early", 10'h044, 8'h00);
        ticks(1'b0, 1);
        rdchk("status due", 10'h044, 8'h01);
        chk("masked irq", 32'h0, {31'h0, tickIrq});
        wr(10'h02c, 8'h00);
        ticks(1'b0, 3000);
        rdchk("status sticky", 10'h044, 8'h01);
        wr(10'h048, 8'h01);
        #1 chk("unmasked irq", 32'h1, {31'h0, tickIrq});
        wr(10'h044, 8'h01);
        ticks(1'b0, 3000);
        rdchk("status off", 10'h044, 8'h00);
    endtask

    // Reset in mid-run must bring the timer back to its off setting
    task automatic t_reset;
        wr(10'h02c, 8'h35);
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("irq after reset", 32'h0, {31'h0, tickIrq});
        rdchk("ctrl after reset", 10'h02c, 8'h00);
    endtask

    task automatic t_restart;
        wr(10'h02c, 8'h10);
        ticks(1'b0, 600);
        period(1'b0, 8'h10, 2 ** 10);
    endtask

    task automatic t_clksel;
        wr(10'h040, 8'h01);
        rdchk("select while down", 10'h040, 8'h00);
        @(posedge clk_sys) oscUp <= 1'b1;
        wr(10'h040, 8'h01);
        rdchk("select while up", 10'h040, 8'h01);
        wr(10'h02c, 8'h10);
        ticks(1'b0, 2000);
        chk("rc ignored", 32'h0, {31'h0, tickIrq});
        period(1'b1, 8'h10, 2 ** 10);
        ticks(1'b1, 500);
        @(posedge clk_sys) oscUp <= 1'b0;
        rdchk("select after loss", 10'h040, 8'h00);
        ticks(1'b0, 2 ** 10 - 1);
        chk("restart on loss", 32'h0, {31'h0, tickIrq});
        ticks(1'b0, 1);
        chk("period on rc", 32'h1, {31'h0, tickIrq});
        wr(10'h044, 8'h01);
    endtask

    task automatic t_stop;
        wr(10'h02c, 8'h10);
        ticks(1'b0, 500);
        @(posedge clk_sys) stopMode <= 1'b1;
        ticks(1'b0, 2000);
        chk("halt in stop", 32'h0, {31'h0, tickIrq});
        @(posedge clk_sys) stopMode <= 1'b0;
        ticks(1'b0, 2 ** 10 - 501);
        chk("count kept early", 32'h0, {31'h0, tickIrq});
        ticks(1'b0, 1);
        chk("count kept due", 32'h1, {31'h0, tickIrq});
        wr(10'h044, 8'h01);
        @(posedge clk_sys) oscUp <= 1'b1;
        wr(10'h040, 8'h05);
        wr(10'h02c, 8'h10);
        @(posedge clk_sys) stopMode <= 1'b1;
        ticks(1'b1, 2000);
        chk("pseudo stop off", 32'h0, {31'h0, tickIrq});
        wr(10'h040, 8'h07);
        period(1'b1, 8'h10, 2 ** 10);
        @(posedge clk_sys) stopMode <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog: the run needs some 55k cycles, allow about 80k
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("irq at reset", 32'h0, {31'h0, tickIrq});
        t_regs();
        t_rates();
        t_off_mask();
        t_restart();
        t_clksel();
        t_stop();
        t_reset();
        tally_and_finish();
    end
endmodule
